// *** dv/haf_rx_model.sv ***
// Receive MAC model that offers frame destinations to the filter.
`timescale 1ns/100ps
`default_nettype none
module haf_rx_model (
  // Clock
  input  wire logic                  clk_i,
  // Frame destination and verdict
  output haf_pkg::haf_frame_t        frame_o,
  input  wire haf_pkg::haf_verdict_t verdict_i
);
  initial frame_o = '0;
  // Waits gap plus one cycles, offers one destination, then reads the verdict.
  task automatic send(input logic [47:0] d, input int gap, output logic v, output logic a);
    repeat (gap + 1) @(posedge clk_i);
    #1 frame_o = {1'b1, d};
    @(posedge clk_i);
    #1 frame_o = {1'b0, ~d};
    v = verdict_i.valid;
    a = verdict_i.accept;
  endtask
endmodule
`default_nettype wire

// *** dv/test_haf_top.sv ***
// Self-checking testbench for the hash address filter.
`timescale 1ns/100ps
`default_nettype none
module test_haf_top;
  logic                  clk_i, rst_i, imp, ho, be, hold, dcl;
  haf_pkg::haf_word_t    sw;
  haf_pkg::haf_frame_t   fr;
  haf_pkg::haf_verdict_t vd;
  logic [31:0]           dw;
  logic [8:0]            tidx;
  logic [47:0]           pa;
  int                    failures, n_compared;
  logic [47:0]           dl [5] = '{48'h002700250025, 48'h820b99c0c2d9, 48'hffffffffffff,
                                    48'h0876353412a8, 48'h0876353412aa};
  haf_top haf_top_i (.clk_i(clk_i), .rst_i(rst_i), .imperfect_mode_i(imp), .hash_only_i(ho),
    .big_endian_i(be), .setup_word_i(sw), .frame_i(fr), .rx_hold_o(hold), .verdict_o(vd),
    .desc_close_o(dcl), .desc_word_o(dw));
  haf_rx_model haf_rx_model_i (.clk_i(clk_i), .frame_o(fr), .verdict_i(vd));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [8:0] hidx(input logic [47:0] d);
    logic [31:0] c;
    c = 32'hffffffff;
    for (int i = 0; i < 48; i++) begin
      c = (c[0] ^ d[i]) ? (c >> 1) ^ 32'hedb88320 : c >> 1;
    end
    return c[8:0];
  endfunction
  // Streams 48 words with one table bit and the station address; the unused half is inverted.
  task automatic load(input logic [8:0] ix, input logic [47:0] p);
    logic [15:0] h;
    tidx = ix;
    pa = p;
    for (int k = 0; k < 48; k++) begin
      h = (k < 32 && k == ix[8:4]) ? 16'h0001 << ix[3:0] : 16'h0000;
      if (k >= 39 && k <= 41) h = p[(k - 39) * 16 +: 16];
      if (be) h = {h[7:0], h[15:8]};
      sw = {1'b1, be ? {h, ~h} : {~h, h}};
      @(posedge clk_i);
      #1;
      if (k == 0) chk(hold, 1);
    end
    sw = '0;
    chk(dcl, 0);
    @(posedge clk_i);
    #1;
    chk(dcl, 1);
    chk(dw, 32'h7fffffff);
    chk(hold, 0);
  endtask
  task automatic filt();
    logic v, a;
    foreach (dl[i]) begin
      haf_rx_model_i.send(dl[i], i, v, a);
      chk(v, 1);
      chk(a, (dl[i][0] | ho) ? hidx(dl[i]) == tidx : dl[i] == pa);
    end
  endtask
  task automatic t_reset();
    chk(dw, 0);
    chk(hold, 0);
  endtask
  task automatic t_imperfect();
    load(hidx(dl[0]), dl[3]);
    filt();
  endtask
  task automatic t_group_not_exact();
    load(hidx(dl[0]), dl[1]);
    filt();
  endtask
  task automatic t_hash_only();
    ho = 1'b1;
    load(hidx(dl[3]), dl[4]);
    filt();
    ho = 1'b0;
  endtask
  task automatic t_big_endian();
    be = 1'b1;
    load(hidx(dl[2]), dl[3]);
    filt();
    be = 1'b0;
  endtask
  // Streams a full buffer of all-ones words with the mode bit low; nothing may change.
  task automatic t_mode_off();
    imp = 1'b0;
    sw = {1'b1, 32'hffffffff};
    repeat (48) @(posedge clk_i);
    #1 sw = '0;
    chk(hold, 0);
    @(posedge clk_i);
    #1;
    chk(dcl, 0);
    imp = 1'b1;
    filt();
  endtask
  task automatic t_hold_drop();
    logic v, a;
    fork
      load(hidx(dl[1]), dl[3]);
      begin
        haf_rx_model_i.send(dl[1], 5, v, a);
        chk(v, 0);
      end
    join
  endtask
  task automatic final_report();
    $display("Compared %0d, failed %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #20000;
    failures++;
    final_report();
  end
  initial begin
    rst_i = 1'b1;
    imp = 1'b1;
    ho = 1'b0;
    be = 1'b0;
    sw = '0;
    repeat (8) @(posedge clk_i);
    #1 rst_i = 1'b0;
    t_reset();
    t_imperfect();
    t_group_not_exact();
    t_hash_only();
    t_big_endian();
    t_mode_off();
    t_hold_drop();
    final_report();
  end
endmodule
`default_nettype wire

// *** hdl/haf_hash.sv ***
// Combinational Ethernet checksum over a destination address, giving the hash index.
`timescale 1ns/100ps
`default_nettype none
module haf_hash (
  // Address in wire order, first byte in bits 7:0
  input  wire logic [47:0] dest_i,
  // Top nine bits of the checksum, bit-reversed into index order
  output logic      [8:0]  index_o
);

  logic [31:0] crc;

  always_comb begin
    crc = haf_pkg::CRC_INIT;
    for (int i = 0; i < 48; i++) begin
      if (crc[31] ^ dest_i[i]) begin
        crc = {crc[30:0], 1'b0} ^ haf_pkg::CRC_POLY;
      end else begin
        crc = {crc[30:0], 1'b0};
      end
    end
    // The index is the low nine bits of the reflected register.
    for (int j = 0; j < 9; j++) begin
      index_o[j] = crc[31 - j];
    end
  end

endmodule
`default_nettype wire

// *** hdl/haf_pkg.sv ***
// Package with constants and carrier types for the hash address filter.
package haf_pkg;

  // ****************************************************************
  // Setup buffer layout
  // ****************************************************************
  localparam int unsigned WORD_W        = 32;
  localparam int unsigned HALF_W        = 16;
  localparam int unsigned TABLE_BITS    = 512;
  localparam int unsigned TABLE_WORDS   = 32;
  localparam int unsigned ADDR_W        = 48;
  localparam int unsigned INDEX_W       = 9;
  localparam int unsigned SETUP_BYTES   = 192;
  localparam int unsigned SETUP_WORDS   = 48;
  localparam logic [5:0]  TABLE_LAST_WD = 6'h1f;
  localparam logic [5:0]  PHYS_FIRST_WD = 6'h27;
  localparam logic [5:0]  PHYS_LAST_WD  = 6'h29;
  localparam logic [5:0]  SETUP_LAST_WD = 6'h2f;
  localparam int unsigned MCAST_BIT     = 0;

  // ****************************************************************
  // Checksum constants
  // ****************************************************************
  localparam logic [31:0] CRC_POLY = 32'h04c11db7;
  localparam logic [31:0] CRC_INIT = 32'hffffffff;

  // ****************************************************************
  // Descriptor close value
  // ****************************************************************
  localparam logic [31:0] DESC_CLOSE = 32'h7fffffff;

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef struct packed {
    logic        valid;
    logic [31:0] data;
  } haf_word_t;

  typedef struct packed {
    logic        valid;
    logic [47:0] dest;
  } haf_frame_t;

  typedef struct packed {
    logic valid;
    logic accept;
  } haf_verdict_t;

endpackage

// *** hdl/haf_top.sv ***
// Receive destination filter with hash table and single physical address.
`timescale 1ns/100ps
`default_nettype none
module haf_top (
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // Mode controls from the operating mode register
  input  wire logic                 imperfect_mode_i,
  input  wire logic                 hash_only_i,
  input  wire logic                 big_endian_i,
  // Setup buffer words, one per cycle, in buffer order
  input  wire haf_pkg::haf_word_t   setup_word_i,
  // Received frame destination
  input  wire haf_pkg::haf_frame_t  frame_i,
  // Receive path hold and verdict
  output logic                      rx_hold_o,
  output haf_pkg::haf_verdict_t     verdict_o,
  // Setup descriptor close
  output logic                      desc_close_o,
  output logic [31:0]               desc_word_o
);

  // ****************************************************************
  // Load state machine
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_LOAD  = 3'b010,
    ST_CLOSE = 3'b100
  } haf_state_t;

  haf_state_t              state_reg, state_next;
  logic [5:0]              wcnt_reg, wcnt_next;
  logic [511:0]            table_reg, table_next;
  logic [47:0]             phys_reg, phys_next;
  logic                    hold_reg, hold_next;
  logic                    close_reg, close_next;
  logic [31:0]             dword_reg, dword_next;
  haf_pkg::haf_verdict_t   verdict_reg, verdict_next;
  logic [15:0]             half;
  logic [8:0]              index;

  function automatic logic [15:0] pick_half(input logic [31:0] w, input logic be);
    logic [15:0] h;
    h = be ? w[31:16] : w[15:0];
    // First byte sits at the lower address in either ordering.
    return be ? {h[7:0], h[15:8]} : h;
  endfunction

  assign half = pick_half(setup_word_i.data, big_endian_i);

  always_comb begin
    state_next = state_reg;
    wcnt_next  = wcnt_reg;
    table_next = table_reg;
    phys_next  = phys_reg;
    hold_next  = hold_reg;
    close_next = 1'b0;
    dword_next = dword_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (setup_word_i.valid && imperfect_mode_i) begin
          state_next = ST_LOAD;
          hold_next  = 1'b1;
        end
      end
      ST_LOAD: begin
      end
      ST_CLOSE: begin
        state_next = ST_IDLE;
        hold_next  = 1'b0;
        close_next = 1'b1;
        dword_next = haf_pkg::DESC_CLOSE;
      end
    endcase
    if (setup_word_i.valid && imperfect_mode_i && state_reg != ST_CLOSE) begin
      if (wcnt_reg <= haf_pkg::TABLE_LAST_WD) begin
        table_next[wcnt_reg[4:0]*16 +: 16] = half;
      end else if (wcnt_reg >= haf_pkg::PHYS_FIRST_WD && wcnt_reg <= haf_pkg::PHYS_LAST_WD) begin
        phys_next[(wcnt_reg - haf_pkg::PHYS_FIRST_WD)*16 +: 16] = half;
      end
      if (wcnt_reg == haf_pkg::SETUP_LAST_WD) begin
        wcnt_next  = 6'h00;
        state_next = ST_CLOSE;
      end else begin
        wcnt_next = wcnt_reg + 6'h01;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      wcnt_reg  <= 6'h00;
      table_reg <= '0;
      phys_reg  <= '0;
      hold_reg  <= 1'b0;
      close_reg <= 1'b0;
      dword_reg <= 32'h00000000;
    end else begin
      state_reg <= state_next;
      wcnt_reg  <= wcnt_next;
      table_reg <= table_next;
      phys_reg  <= phys_next;
      hold_reg  <= hold_next;
      close_reg <= close_next;
      dword_reg <= dword_next;
    end
  end

  // ****************************************************************
  // Frame decision
  // ****************************************************************
  haf_hash u_hash (
    .dest_i  (frame_i.dest),
    .index_o (index)
  );

  always_comb begin
    verdict_next.valid  = frame_i.valid && !hold_reg;
    verdict_next.accept = 1'b0;
    // Broadcast has its multicast bit set, so it takes the table path.
    if (frame_i.dest[haf_pkg::MCAST_BIT] || hash_only_i) begin
      verdict_next.accept = table_reg[index];
    end else begin
      verdict_next.accept = (frame_i.dest == phys_reg);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      verdict_reg <= '0;
    end else begin
      verdict_reg <= verdict_next;
    end
  end

  assign rx_hold_o    = hold_reg;
  assign verdict_o    = verdict_reg;
  assign desc_close_o = close_reg;
  assign desc_word_o  = dword_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_close_word: assert property (@(posedge clk_i) disable iff (rst_i)
    desc_close_o |-> desc_word_o == haf_pkg::DESC_CLOSE) else $error("bad close word");
  a_hold_load: assert property (@(posedge clk_i) disable iff (rst_i)
    desc_close_o |-> $past(rx_hold_o)) else $error("hold missing while loading");
  a_no_verdict_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_hold_o |=> !verdict_o.valid) else $error("verdict during load");
  a_phys_match: assert property (@(posedge clk_i) disable iff (rst_i)
    (frame_i.valid && !hold_reg && !hash_only_i && !frame_i.dest[0])
    |=> verdict_o.accept == ($past(frame_i.dest) == $past(phys_reg)))
    else $error("physical compare wrong");
  a_mcast_hash: assert property (@(posedge clk_i) disable iff (rst_i)
    (frame_i.valid && frame_i.dest[0])
    |=> verdict_o.accept == $past(table_reg[index])) else $error("hash lookup wrong");
  a_hash_only: assert property (@(posedge clk_i) disable iff (rst_i)
    (frame_i.valid && hash_only_i) |=> verdict_o.accept == $past(table_reg[index]))
    else $error("hash-only path wrong");
  a_load_mode: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == ST_IDLE && setup_word_i.valid && !imperfect_mode_i) |=> state_reg == ST_IDLE)
    else $error("load outside imperfect mode");
  a_close_once: assert property (@(posedge clk_i) disable iff (rst_i)
    desc_close_o |-> !rx_hold_o ##1 !desc_close_o) else $error("close repeated");

  // ****************************************************************
  // Load sequence and frame checks
  // ****************************************************************
  // A word is taken on an edge where it is valid, the mode bit is set and the state is not ST_CLOSE.
  sequence s_first_word;
    state_reg == ST_IDLE && setup_word_i.valid && imperfect_mode_i;
  endsequence

  sequence s_last_word;
    state_reg == ST_LOAD && setup_word_i.valid && imperfect_mode_i &&
    wcnt_reg == haf_pkg::SETUP_LAST_WD;
  endsequence

  // The receive path stays held through the close cycle and is freed with the close pulse.
  sequence s_close_out;
    rx_hold_o && !desc_close_o ##1 desc_close_o && !rx_hold_o;
  endsequence

  a_hold_rise: assert property (@(posedge clk_i) disable iff (rst_i)
    s_first_word |=> rx_hold_o && !desc_close_o) else $error("hold not raised at load");
  a_close_after: assert property (@(posedge clk_i) disable iff (rst_i)
    s_last_word |=> s_close_out) else $error("close not after last word");
  a_close_stays: assert property (@(posedge clk_i) disable iff (rst_i)
    desc_close_o |=> desc_word_o == haf_pkg::DESC_CLOSE) else $error("close word lost");
  a_mode_ignore: assert property (@(posedge clk_i) disable iff (rst_i)
    (setup_word_i.valid && !imperfect_mode_i) |=> $stable(wcnt_reg))
    else $error("word taken outside imperfect mode");
  a_table_half: assert property (@(posedge clk_i) disable iff (rst_i)
    (setup_word_i.valid && imperfect_mode_i && state_reg != ST_CLOSE && wcnt_reg == 6'h00)
    |=> table_reg[15:0] == $past(big_endian_i ? {setup_word_i.data[23:16],
    setup_word_i.data[31:24]} : setup_word_i.data[15:0])) else $error("table half wrong");
  a_phys_half: assert property (@(posedge clk_i) disable iff (rst_i)
    (setup_word_i.valid && imperfect_mode_i && wcnt_reg == haf_pkg::PHYS_FIRST_WD)
    |=> phys_reg[15:0] == $past(big_endian_i ? {setup_word_i.data[23:16],
    setup_word_i.data[31:24]} : setup_word_i.data[15:0])) else $error("address half wrong");
  a_broadcast: assert property (@(posedge clk_i) disable iff (rst_i)
    (frame_i.valid && (&frame_i.dest)) |=> verdict_o.accept == $past(table_reg[index]))
    else $error("broadcast not hashed");
  a_verdict_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    !frame_i.valid |=> !verdict_o.valid) else $error("verdict without frame");

endmodule
`default_nettype wire
